// ===== cgc_pkg.sv
`default_nettype none
package cgc_pkg;

  // ***************************************************
  // Register locations
  // ***************************************************
  localparam logic [7:0] TRIM_ADDR = 8'h96;
  localparam logic [7:0] DIV_ADDR = 8'h95;
  localparam logic [7:0] AUX1_ADDR = 8'ha2;
  localparam logic [15:0] HOLD_ADDR = 16'hffd0;

  // ***************************************************
  // Field positions and reset values
  // ***************************************************
  localparam int TRIM_RCSEL_BIT = 7;
  localparam int TRIM_CLKOUT_BIT = 6;
  localparam int TRIM_W = 6;
  localparam int AUX1_LP_BIT = 7;
  localparam int HOLD_W = 5;
  localparam logic [7:0] TRIM_CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [HOLD_W-1:0] HOLD_RST = 5'h00;

  // Clock hold bit order: rtc, capture unit, watchdog, timer 1, timer 0
  localparam int HOLD_RTC = 4;
  localparam int HOLD_CCU = 3;
  localparam int HOLD_WDT = 2;
  localparam int HOLD_T1 = 1;
  localparam int HOLD_T0 = 0;

  // ***************************************************
  // Source selection codes and crystal ranges
  // ***************************************************
  typedef enum logic [1:0] {
    CGC_SRC_WDOG,
    CGC_SRC_RC,
    CGC_SRC_XTAL,
    CGC_SRC_EXT
  } cgc_src_t;

  typedef enum logic [1:0] {
    CGC_XTAL_LOW,
    CGC_XTAL_MED,
    CGC_XTAL_HIGH,
    CGC_XTAL_RSVD
  } cgc_xrange_t;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_XTAL_OSC = 992;
  localparam int WAKE_OTHER_OSC = 224;
  localparam int WAKE_EXTRA_NS = 60000;
  localparam int WAKE_EXTRA_CYC = (WAKE_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 11;
  localparam int CPU_CORE_CLOCK_PER_MCYC = 2;

endpackage
`default_nettype wire

// ===== cgc_tick_if.sv
`default_nettype none
interface cgc_tick_if #(parameter int DIV_W = 8);
  logic osc_tick;
  logic run;
  logic [DIV_W-1:0] div_val;
  logic core_tick;
  logic pclk_tick;
  logic mcyc_tick;

  modport ctrl (output osc_tick, output run, output div_val, input core_tick, input pclk_tick, input mcyc_tick);
  modport div (input osc_tick, input run, input div_val, output core_tick, output pclk_tick, output mcyc_tick);
endinterface
`default_nettype wire

// ===== cgc_divider.sv
`default_nettype none
module cgc_divider #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Tick carrier
  cgc_tick_if.div tk
);

  initial begin
    if (DIV_W != 8) begin
      $error("cgc_divider: divider width must be 8");
    end
  end

  logic [DIV_W:0] cnt_q;
  logic core_tick_q;
  logic pclk_ph_q;
  logic mcyc_ph_q;
  logic [DIV_W:0] limit;

  // ***************************************************
  // Oscillator divide by twice the setting, or by 1 when zero
  // ***************************************************
  assign limit = {tk.div_val, 1'b0};

  // Comparing with >= lets core_clock_divider change at any time without a stall
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      core_tick_q <= 1'b0;
    end else begin
      core_tick_q <= 1'b0;
      if (tk.osc_tick) begin
        if (tk.div_val == '0 || cnt_q + 1'b1 >= limit) begin
          cnt_q <= '0;
          core_tick_q <= tk.run;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // ***************************************************
  // Peripheral clock and machine cycle
  // ***************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pclk_ph_q <= 1'b0;
      mcyc_ph_q <= 1'b0;
    end else if (core_tick_q) begin
      pclk_ph_q <= ~pclk_ph_q;
      mcyc_ph_q <= ~mcyc_ph_q;
    end
  end

  assign tk.core_tick = core_tick_q;
  assign tk.pclk_tick = core_tick_q & pclk_ph_q;
  assign tk.mcyc_tick = core_tick_q & mcyc_ph_q;

endmodule
`default_nettype wire

// ===== cgc_top.sv
// Summary of operation
// - Machine cycle equals two CPU clock cycles
// - Peripheral clock runs at half CPU clock
// - One of four sources, divided, forms CPU clock
// - Source choice comes from non-volatile configuration
// - Crystal has low, medium, high ranges
// - Clock output only when no crystal used
// - Clock output runs at half CPU clock
// - Six-bit trim loaded at reset, software writable
// - RC nominal 7.373 MHz, doubled 14.746 MHz
// - Low-power select cleared by every reset
// - Watchdog oscillator may be main source
// - External clock on crystal input, 0 to 18 MHz
// - Clock hold register lives in external data space
// - Wake-up gates CPU clock 992 or 224 plus delay
// - Divider up to 510, changeable any time
`default_nettype none
module cgc_top #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Non-volatile configuration
  input wire cgc_pkg::cgc_src_t cfg_source,
  input wire cgc_pkg::cgc_xrange_t cfg_xtal_range,
  input wire logic cfg_rc_doubler,
  input wire logic cfg_rtc_on_crystal,
  input wire logic [cgc_pkg::TRIM_W-1:0] factory_trim,
  // Oscillator and pin levels
  input wire logic crystal_in_pin,
  input wire logic rc_osc_clock,
  input wire logic wdog_osc_clock,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // External data register port
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_wr,
  input wire logic xdata_rd,
  input wire logic [7:0] xdata_wdata,
  output logic [7:0] xdata_rdata,
  output logic xdata_hit,
  // Power management
  input wire logic wake_req,
  output logic cpu_gated,
  // Clock ticks
  output logic source_osc_tick,
  output logic cpu_core_tick,
  output logic periph_tick,
  output logic mcycle_tick,
  output logic [cgc_pkg::HOLD_W-1:0] periph_run_tick,
  // Analog controls
  output logic [cgc_pkg::TRIM_W-1:0] rc_trim,
  output logic rc_double_en,
  output cgc_pkg::cgc_xrange_t xtal_gain_sel,
  output logic xtal_osc_en,
  output logic low_power_clock_select,
  // Clock output pin
  output logic crystal_out_clock_pin_o,
  output logic crystal_out_clock_pin_oe
);

  initial begin
    if (DIV_W != 8) begin
      $error("cgc_top: divider width must be 8");
    end
  end

  cgc_tick_if #(.DIV_W(DIV_W)) tk ();

  // ***************************************************
  // Register state
  // ***************************************************
  logic [7:0] trim_q;
  logic trim_loaded_q;
  logic [DIV_W-1:0] core_clock_divider_q;
  logic low_power_q;
  logic [cgc_pkg::HOLD_W-1:0] hold_q;
  logic [7:0] sfr_rdata_q;
  logic [7:0] xdata_rdata_q;
  logic xdata_hit_q;
  logic clock_out_enable;
  logic crystal_in_use;
  logic hold_sel;

  assign clock_out_enable = trim_q[cgc_pkg::TRIM_CLKOUT_BIT];
  assign hold_sel = (xdata_addr == cgc_pkg::HOLD_ADDR);

  // Trim catches the factory value on the first edge after reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim_q <= cgc_pkg::TRIM_CTRL_RST;
      trim_loaded_q <= 1'b0;
    end else begin
      trim_loaded_q <= 1'b1;
      if (!trim_loaded_q) begin
        trim_q[cgc_pkg::TRIM_W-1:0] <= factory_trim;
      end else if (sfr_wr && sfr_addr == cgc_pkg::TRIM_ADDR) begin
        trim_q <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_clock_divider_q <= cgc_pkg::DIV_RST;
    end else if (sfr_wr && sfr_addr == cgc_pkg::DIV_ADDR) begin
      core_clock_divider_q <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_power_q <= 1'b0;
    end else if (sfr_wr && sfr_addr == cgc_pkg::AUX1_ADDR) begin
      low_power_q <= sfr_wdata[cgc_pkg::AUX1_LP_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= cgc_pkg::HOLD_RST;
    end else if (xdata_wr && hold_sel) begin
      hold_q <= xdata_wdata[cgc_pkg::HOLD_W-1:0];
    end
  end

  // ***************************************************
  // Read data, one cycle after the strobe
  // ***************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        cgc_pkg::TRIM_ADDR: sfr_rdata_q <= trim_q;
        cgc_pkg::DIV_ADDR: sfr_rdata_q <= core_clock_divider_q;
        cgc_pkg::AUX1_ADDR: sfr_rdata_q <= {low_power_q, 7'h00};
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xdata_rdata_q <= 8'h00;
      xdata_hit_q <= 1'b0;
    end else begin
      xdata_hit_q <= (xdata_rd | xdata_wr) & hold_sel;
      if (xdata_rd) begin
        xdata_rdata_q <= hold_sel ? {3'h0, hold_q} : 8'h00;
      end
    end
  end

  // ***************************************************
  // Oscillator level synchronisers and edge ticks
  // ***************************************************
  logic [2:0] xin_s_q;
  logic [2:0] rc_s_q;
  logic [2:0] wd_s_q;
  logic osc_tick_q;
  logic rc_rise;
  logic rc_fall;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xin_s_q <= 3'h0;
      rc_s_q <= 3'h0;
      wd_s_q <= 3'h0;
    end else begin
      xin_s_q <= {xin_s_q[1:0], crystal_in_pin};
      rc_s_q <= {rc_s_q[1:0], rc_osc_clock};
      wd_s_q <= {wd_s_q[1:0], wdog_osc_clock};
    end
  end

  assign rc_rise = rc_s_q[1] & ~rc_s_q[2];
  assign rc_fall = ~rc_s_q[1] & rc_s_q[2];

  // Source choice is fixed by configuration, not software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_tick_q <= 1'b0;
    end else begin
      case (cfg_source)
        cgc_pkg::CGC_SRC_WDOG: osc_tick_q <= wd_s_q[1] & ~wd_s_q[2];
        cgc_pkg::CGC_SRC_RC: osc_tick_q <= rc_rise | (cfg_rc_doubler & rc_fall);
        cgc_pkg::CGC_SRC_XTAL: osc_tick_q <= xin_s_q[1] & ~xin_s_q[2];
        cgc_pkg::CGC_SRC_EXT: osc_tick_q <= xin_s_q[1] & ~xin_s_q[2];
        default: osc_tick_q <= 1'b0;
      endcase
    end
  end

  // ***************************************************
  // Wake-up gate
  // ***************************************************
  typedef enum logic [1:0] {
    CGC_RUN,
    CGC_WAIT_OSC,
    CGC_WAIT_FIX
  } cgc_wake_t;

  cgc_wake_t wake_q;
  logic [cgc_pkg::WAKE_CNT_W-1:0] wcnt_q;
  logic [cgc_pkg::WAKE_CNT_W-1:0] osc_wait;

  assign osc_wait = (cfg_source == cgc_pkg::CGC_SRC_XTAL)
    ? cgc_pkg::WAKE_CNT_W'(cgc_pkg::WAKE_XTAL_OSC - 1)
    : cgc_pkg::WAKE_CNT_W'(cgc_pkg::WAKE_OTHER_OSC - 1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_q <= CGC_RUN;
      wcnt_q <= '0;
    end else begin
      case (wake_q)
        CGC_RUN: begin
          if (wake_req) begin
            wake_q <= CGC_WAIT_OSC;
            wcnt_q <= '0;
          end
        end
        CGC_WAIT_OSC: begin
          if (osc_tick_q) begin
            if (wcnt_q == osc_wait) begin
              wake_q <= CGC_WAIT_FIX;
              wcnt_q <= '0;
            end else begin
              wcnt_q <= wcnt_q + 1'b1;
            end
          end
        end
        CGC_WAIT_FIX: begin
          if (wcnt_q == cgc_pkg::WAKE_CNT_W'(cgc_pkg::WAKE_EXTRA_CYC - 1)) begin
            wake_q <= CGC_RUN;
          end else begin
            wcnt_q <= wcnt_q + 1'b1;
          end
        end
        default: wake_q <= CGC_RUN;
      endcase
    end
  end

  // ***************************************************
  // Divider and derived clocks
  // ***************************************************
  assign tk.osc_tick = osc_tick_q;
  assign tk.run = (wake_q == CGC_RUN);
  assign tk.div_val = core_clock_divider_q;

  cgc_divider #(.DIV_W(DIV_W)) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .tk(tk)
  );

  // ***************************************************
  // Clock output pin
  // ***************************************************
  logic clkout_q;
  logic clkout_oe_q;

  assign crystal_in_use = (cfg_source == cgc_pkg::CGC_SRC_XTAL) | cfg_rtc_on_crystal;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkout_q <= 1'b0;
      clkout_oe_q <= 1'b0;
    end else begin
      clkout_oe_q <= clock_out_enable & ~crystal_in_use;
      if (!(clock_out_enable & ~crystal_in_use)) begin
        clkout_q <= 1'b0;
      end else if (tk.core_tick) begin
        clkout_q <= ~clkout_q;
      end
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign sfr_rdata = sfr_rdata_q;
  assign xdata_rdata = xdata_rdata_q;
  assign xdata_hit = xdata_hit_q;
  assign cpu_gated = (wake_q != CGC_RUN);
  assign source_osc_tick = osc_tick_q;
  assign cpu_core_tick = tk.core_tick;
  assign periph_tick = tk.pclk_tick;
  assign mcycle_tick = tk.mcyc_tick;
  assign periph_run_tick = {cgc_pkg::HOLD_W{tk.pclk_tick}} & ~hold_q;
  assign rc_trim = trim_q[cgc_pkg::TRIM_W-1:0];
  assign rc_double_en = cfg_rc_doubler;
  assign xtal_gain_sel = cfg_xtal_range;
  assign xtal_osc_en = crystal_in_use;
  assign low_power_clock_select = low_power_q;
  assign crystal_out_clock_pin_o = clkout_q;
  assign crystal_out_clock_pin_oe = clkout_oe_q;

endmodule
`default_nettype wire

// ===== cgc_asserts.sv
`default_nettype none
module cgc_top_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire cgc_pkg::cgc_src_t cfg_source,
  input wire cgc_pkg::cgc_xrange_t cfg_xtal_range,
  input wire logic cfg_rc_doubler,
  input wire logic cfg_rtc_on_crystal,
  input wire logic [cgc_pkg::TRIM_W-1:0] factory_trim,
  // External data port
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_wr,
  input wire logic xdata_rd,
  input wire logic xdata_hit,
  // Wake and ticks
  input wire logic wake_req,
  input wire logic cpu_gated,
  input wire logic cpu_core_tick,
  input wire logic periph_tick,
  input wire logic mcycle_tick,
  input wire logic [cgc_pkg::HOLD_W-1:0] periph_run_tick,
  // Controls and pin
  input wire logic [cgc_pkg::TRIM_W-1:0] rc_trim,
  input wire logic rc_double_en,
  input wire cgc_pkg::cgc_xrange_t xtal_gain_sel,
  input wire logic low_power_clock_select,
  input wire logic crystal_out_clock_pin_o,
  input wire logic crystal_out_clock_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // CPU ticks seen since the last peripheral tick
  logic [1:0] since_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_q <= 2'h0;
    end else if (periph_tick) begin
      since_q <= 2'h0;
    end else if (cpu_core_tick && since_q != 2'h3) begin
      since_q <= since_q + 2'h1;
    end
  end

  sequence s_release;
    $past(sys_rst) && !sys_rst;
  endsequence
  sequence s_hold_access;
    (xdata_rd || xdata_wr) && xdata_addr == cgc_pkg::HOLD_ADDR;
  endsequence

  AST_MCYCLE: assert property (cpu_core_tick |-> mcycle_tick == (since_q == 2'h1))
    else $error("machine cycle tick not on every second cpu tick");
  AST_PCLK: assert property (cpu_core_tick |-> periph_tick == (since_q == 2'h1))
    else $error("peripheral tick not on every second cpu tick");
  AST_PCLK_ALIGN: assert property (periph_tick |-> cpu_core_tick)
    else $error("peripheral tick without cpu tick");
  AST_TRIM_LOAD: assert property (s_release |=> rc_trim == $past(factory_trim))
    else $error("trim not loaded with factory value");
  AST_LP_CLEAR: assert property (s_release |-> !low_power_clock_select)
    else $error("low power select set after reset");
  AST_DOUBLER: assert property (rc_double_en == cfg_rc_doubler)
    else $error("doubler enable differs from configuration");
  AST_RANGE: assert property (xtal_gain_sel == cfg_xtal_range)
    else $error("crystal range differs from configuration");
  AST_OUT_GATE: assert property (crystal_out_clock_pin_oe |->
    $past(cfg_source) != cgc_pkg::CGC_SRC_XTAL && !$past(cfg_rtc_on_crystal))
    else $error("clock output driven while crystal in use");
  AST_OUT_TOGGLE: assert property (crystal_out_clock_pin_oe && $past(crystal_out_clock_pin_oe) &&
    $changed(crystal_out_clock_pin_o) |-> cpu_core_tick || $past(cpu_core_tick))
    else $error("clock output moved without cpu tick");
  AST_HOLD_HIT: assert property (s_hold_access |=> xdata_hit)
    else $error("hold register access not acknowledged");
  AST_HOLD_MISS: assert property ((xdata_rd || xdata_wr) && xdata_addr != cgc_pkg::HOLD_ADDR |=> !xdata_hit)
    else $error("unmapped external access acknowledged");
  AST_RUN_MASK: assert property (|periph_run_tick |-> periph_tick)
    else $error("peripheral run tick without peripheral tick");
  AST_WAKE_GATE: assert property (wake_req && !cpu_gated |=> cpu_gated [*8])
    else $error("wake request did not gate the cpu clock");
  AST_WAKE_QUIET: assert property (cpu_gated && $past(cpu_gated) |-> !cpu_core_tick)
    else $error("cpu tick while gated");
endmodule

bind cgc_top cgc_top_asserts u_chk (.clk, .sys_rst, .cfg_source, .cfg_xtal_range, .cfg_rc_doubler,
  .cfg_rtc_on_crystal, .factory_trim, .xdata_addr, .xdata_wr, .xdata_rd, .xdata_hit, .wake_req,
  .cpu_gated, .cpu_core_tick, .periph_tick, .mcycle_tick, .periph_run_tick, .rc_trim, .rc_double_en,
  .xtal_gain_sel, .low_power_clock_select, .crystal_out_clock_pin_o, .crystal_out_clock_pin_oe);
`default_nettype wire

// ===== cgc_osc_model.sv
`default_nettype none
module cgc_osc_model #(
  parameter int WDOG_HALF_NS = 1250,
  parameter int RC_HALF_NS = 100,
  parameter int XTAL_HALF_NS = 160
) (
  // Oscillator levels
  output logic crystal_in_pin,
  output logic rc_osc_clock,
  output logic wdog_osc_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  // RC slowed to 5 MHz, the nominal rate is beyond 25 MHz sampling
  initial begin
    rc_osc_clock = 1'b0;
    #3;
    forever #(RC_HALF_NS) rc_osc_clock = ~rc_osc_clock;
  end
  initial begin
    wdog_osc_clock = 1'b0;
    #7;
    forever #(WDOG_HALF_NS) wdog_osc_clock = ~wdog_osc_clock;
  end
  // Medium range crystal, also standing in for an external clock
  // Kept below 12 MHz, so no external reset hold is owed
  initial begin
    crystal_in_pin = 1'b0;
    #11;
    forever #(XTAL_HALF_NS) crystal_in_pin = ~crystal_in_pin;
  end
endmodule
`default_nettype wire

// ===== cgc_top_bench.sv
`default_nettype none
module cgc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] A_TRIM = {8'h00, cgc_pkg::TRIM_ADDR};
  localparam logic [15:0] A_DIV = {8'h00, cgc_pkg::DIV_ADDR};
  localparam logic [15:0] A_AUX = {8'h00, cgc_pkg::AUX1_ADDR};
  localparam logic [15:0] A_HOLD = cgc_pkg::HOLD_ADDR;
  logic clk, sys_rst, cfg_rc_doubler, cfg_rtc_on_crystal, crystal_in_pin, rc_osc_clock, wdog_osc_clock;
  cgc_pkg::cgc_src_t cfg_source;
  cgc_pkg::cgc_xrange_t cfg_xtal_range, xtal_gain_sel;
  logic [5:0] factory_trim, rc_trim;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, xdata_rdata;
  logic sfr_wr, sfr_rd, xdata_wr, xdata_rd, xdata_hit, wake_req, cpu_gated, hit_s, pin_q;
  logic [15:0] xdata_addr;
  logic source_osc_tick, cpu_core_tick, periph_tick, mcycle_tick, rc_double_en, xtal_osc_en;
  logic low_power_clock_select, crystal_out_clock_pin_o, crystal_out_clock_pin_oe;
  logic [4:0] periph_run_tick;
  int n_fail, checks;
  int cnt[5], s[5];

  cgc_top dut (.clk, .sys_rst, .cfg_source, .cfg_xtal_range, .cfg_rc_doubler, .cfg_rtc_on_crystal,
    .factory_trim, .crystal_in_pin, .rc_osc_clock, .wdog_osc_clock, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .xdata_addr, .xdata_wr, .xdata_rd, .xdata_wdata, .xdata_rdata, .xdata_hit,
    .wake_req, .cpu_gated, .source_osc_tick, .cpu_core_tick, .periph_tick, .mcycle_tick,
    .periph_run_tick, .rc_trim, .rc_double_en, .xtal_gain_sel, .xtal_osc_en, .low_power_clock_select,
    .crystal_out_clock_pin_o, .crystal_out_clock_pin_oe);
  cgc_osc_model osc (.crystal_in_pin, .rc_osc_clock, .wdog_osc_clock);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ***************************************************
  // Tick and pin toggle counters
  // ***************************************************
  always @(posedge clk) begin
    cnt[0] <= cnt[0] + int'(source_osc_tick);
    cnt[1] <= cnt[1] + int'(cpu_core_tick);
    cnt[2] <= cnt[2] + int'(periph_tick);
    cnt[3] <= cnt[3] + int'(mcycle_tick);
    cnt[4] <= cnt[4] + int'(crystal_out_clock_pin_o != pin_q);
    pin_q <= crystal_out_clock_pin_o;
  end

  task automatic chk(string w, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic rng(string w, int seen, int lo, int hi);
    checks++;
    if (seen < lo || seen > hi) begin
      n_fail++;
      $display("wrong value %s expected %0d..%0d seen %0d", w, lo, hi, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic acc(input bit x, input bit w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    if (x) begin
      xdata_addr <= a;
      xdata_wdata <= d;
      xdata_wr <= w;
      xdata_rd <= !w;
    end else begin
      sfr_addr <= a[7:0];
      sfr_wdata <= d;
      sfr_wr <= w;
      sfr_rd <= !w;
    end
    @(posedge clk);
    {xdata_wr, xdata_rd, sfr_wr, sfr_rd} <= 4'h0;
    @(negedge clk);
    q = x ? xdata_rdata : sfr_rdata;
    hit_s = xdata_hit;
  endtask

  task automatic t_regs(input logic [5:0] f);
    logic [7:0] q;
    @(posedge clk);
    factory_trim <= f;
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    acc(0, 0, A_TRIM, 8'h00, q);
    chk("trim", q, {2'h0, f});
    acc(0, 0, A_DIV, 8'h00, q);
    chk("divider", q, 8'h00);
    acc(0, 0, A_AUX, 8'h00, q);
    chk("aux", q, 8'h00);
    acc(1, 0, A_HOLD, 8'h00, q);
    chk("hold", q, 8'h00);
    acc(0, 0, 16'h0080, 8'h00, q);
    chk("unmapped sfr", q, 8'h00);
    acc(0, 1, A_TRIM, 8'h55, q);
    acc(0, 0, A_TRIM, 8'h00, q);
    chk("trim rw", q, 8'h55);
    chk("rc_trim", 8'(rc_trim), 8'h15);
    acc(0, 1, A_AUX, 8'hff, q);
    acc(0, 0, A_AUX, 8'h00, q);
    chk("aux rw", q, 8'h80);
    chk("low power", 8'(low_power_clock_select), 8'h01);
  endtask

  task automatic t_src;
    int e[4] = '{32, 400, 250, 250};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cfg_source <= cgc_pkg::cgc_src_t'(k);
      repeat (50) @(posedge clk);
      s = cnt;
      repeat (2000) @(posedge clk);
      rng("osc ticks", cnt[0] - s[0], e[k] - 3, e[k] + 3);
      @(negedge clk);
      chk("clock out oe", 8'(crystal_out_clock_pin_oe), 8'(k != 2));
      chk("crystal enable", 8'(xtal_osc_en), 8'(k == 2));
    end
    @(posedge clk);
    cfg_source <= cgc_pkg::CGC_SRC_RC;
    cfg_rtc_on_crystal <= 1'b1;
    repeat (10) @(negedge clk);
    chk("oe with rtc crystal", 8'(crystal_out_clock_pin_oe), 8'h00);
    chk("pin idle", 8'(crystal_out_clock_pin_o), 8'h00);
    @(posedge clk);
    cfg_rtc_on_crystal <= 1'b0;
    cfg_rc_doubler <= 1'b1;
    repeat (50) @(posedge clk);
    s = cnt;
    repeat (2000) @(posedge clk);
    rng("doubled rc ticks", cnt[0] - s[0], 797, 803);
    chk("doubler", 8'(rc_double_en), 8'h01);
    cfg_rc_doubler <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      cfg_xtal_range <= cgc_pkg::cgc_xrange_t'(r);
      repeat (2) @(negedge clk);
      chk("gain select", 8'(xtal_gain_sel), 8'(r));
      @(posedge clk);
    end
  endtask

  task automatic t_div;
    int dv[4] = '{255, 3, 1, 0};
    int c, p;
    logic [7:0] q;
    for (int i = 0; i < 4; i++) begin
      acc(0, 1, A_DIV, 8'(dv[i]), q);
      repeat (20) @(posedge clk);
      s = cnt;
      repeat (6000) @(posedge clk);
      c = (cnt[0] - s[0]) / (dv[i] == 0 ? 1 : 2 * dv[i]);
      rng("cpu ticks", cnt[1] - s[1], c - 1, c + 1);
      p = (cnt[1] - s[1]) / 2;
      rng("periph ticks", cnt[2] - s[2], p - 1, p + 1);
      rng("mcycle ticks", cnt[3] - s[3], cnt[2] - s[2], cnt[2] - s[2]);
      rng("pin toggles", cnt[4] - s[4], cnt[1] - s[1] - 1, cnt[1] - s[1] + 1);
    end
  endtask

  task automatic t_hold;
    logic [7:0] q;
    logic [4:0] seen;
    acc(1, 1, A_HOLD, 8'hff, q);
    acc(1, 0, A_HOLD, 8'h00, q);
    chk("hold rw", q, 8'h1f);
    chk("hold hit", 8'(hit_s), 8'h01);
    acc(1, 1, A_HOLD, 8'h15, q);
    seen = 5'h00;
    repeat (300) @(negedge clk) seen |= periph_run_tick;
    chk("run ticks", 8'(seen), 8'h0a);
    acc(1, 1, 16'hffd1, 8'h00, q);
    chk("miss hit", 8'(hit_s), 8'h00);
    acc(1, 0, 16'hffd1, 8'h00, q);
    chk("miss read", q, 8'h00);
    acc(1, 0, A_HOLD, 8'h00, q);
    chk("hold kept", q, 8'h15);
    acc(1, 1, A_HOLD, 8'h00, q);
    // Software drops the clock output before idle
    acc(0, 1, A_TRIM, 8'h15, q);
    repeat (2) @(negedge clk);
    chk("oe before idle", 8'(crystal_out_clock_pin_oe), 8'h00);
    chk("pin before idle", 8'(crystal_out_clock_pin_o), 8'h00);
  endtask

  task automatic t_wake(input cgc_pkg::cgc_src_t k, input int n, input int per);
    int cyc, c0;
    @(posedge clk);
    cfg_source <= k;
    repeat (100) @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    s = cnt;
    @(negedge clk);
    chk("gated", 8'(cpu_gated), 8'h01);
    // A cpu tick launched before the gate closes may still show here
    @(negedge clk);
    c0 = cnt[1];
    cyc = 2;
    while (cpu_gated === 1'b1 && cyc < 20000) begin
      @(negedge clk);
      cyc++;
    end
    rng("wake osc ticks", cnt[0] - s[0], n, n + 1500 / per + 4);
    rng("wake cycles", cyc, 1500, n * per + 1520);
    rng("gated cpu ticks", cnt[1] - c0, 0, 0);
  endtask

  initial begin
    sys_rst = 1'b1;
    cfg_source = cgc_pkg::CGC_SRC_RC;
    cfg_xtal_range = cgc_pkg::CGC_XTAL_MED;
    cfg_rc_doubler = 1'b0;
    cfg_rtc_on_crystal = 1'b0;
    factory_trim = 6'h2a;
    {sfr_addr, sfr_wdata, xdata_wdata, xdata_addr} = 40'h0;
    {sfr_wr, sfr_rd, xdata_wr, xdata_rd, wake_req} = 5'h00;
    t_regs(6'h2a);
    t_regs(6'h15);
    t_src;
    t_div;
    t_hold;
    t_wake(cgc_pkg::CGC_SRC_RC, 224, 5);
    t_wake(cgc_pkg::CGC_SRC_XTAL, 992, 8);
    wrap_up;
  end

  initial begin
    #(40 * 80000);
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
